/* logic/backup_domain_tamper_store.sv */
// Backup domain user words with tamper erase and calibration output
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module backup_domain_tamper_store #(
  parameter int CAL_WIN_LOG2 = bkup_pkg::CAL_WIN_LOG2_DEF
) (
  // Clock and backup domain reset
  input  wire logic                core_clk,
  input  wire logic                rst,
  // Access gating from power and clock control
  input  wire logic                power_iface_clock_enable,
  input  wire logic                backup_iface_clock_enable,
  input  wire logic                domain_write_unlock,
  // Avalon-MM slave
  input  wire bkup_pkg::avmm_req_t bus_req,
  output var  bkup_pkg::avmm_rsp_t bus_rsp,
  // Tamper pin
  input  wire logic                tamper_pin_in,
  output logic                     tamper_pin_out,
  output logic                     tamper_pin_oe,
  // RTC side
  input  wire logic                alarm_pulse,
  input  wire logic                second_pulse,
  output logic                     rtc_tick,
  output logic                     tamper_irq
);
  import bkup_pkg::*;

  if (CAL_WIN_LOG2 < 8 || CAL_WIN_LOG2 > 24)
  begin : g_bad_win
    $error("CAL_WIN_LOG2 must lie in 8..24");
  end

  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  be);
    merge16 = {be[1] ? new_v[15:8] : old_v[15:8],
               be[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction

  // Returns {valid, index}; the map has a hole at 0x2C..0x3C
  function automatic logic [IDX_W:0] decode(input logic [8:0] a);
    logic [8:0] lo;
    logic [8:0] hi;
    lo = a - LOW_FIRST;
    hi = a - HIGH_FIRST;
    decode = '0;
    if (a[1:0] == 2'h0 && a >= LOW_FIRST && a <= LOW_LAST)
      decode = {1'b1, lo[7:2]};
    else if (a[1:0] == 2'h0 && a >= HIGH_FIRST && a <= HIGH_LAST)
      decode = {1'b1, LOW_COUNT + hi[7:2]};
  endfunction

  // State
  logic [WORD_W-1:0]       mem [NUM_WORDS];
  logic [WORD_W-1:0]       next_mem [NUM_WORDS];
  cal_cfg_t                cal;
  cal_cfg_t                next_cal;
  tamper_ctrl_t            ctrl;
  tamper_ctrl_t            next_ctrl;
  logic                    irq_en;
  logic                    next_irq_en;
  logic                    evt_flag;
  logic                    next_evt_flag;
  logic                    irq_flag;
  logic                    next_irq_flag;
  avmm_rsp_t               next_rsp;
  logic                    pin_meta;
  logic                    pin_sync;
  logic                    det_prev;
  logic                    next_det_prev;
  logic                    toggle_q;
  logic                    next_toggle_q;
  logic                    next_pin_out;
  logic                    next_pin_oe;
  logic                    next_rtc_tick;
  logic [DIV_LOG2-1:0]     div_cnt;
  logic [DIV_LOG2-1:0]     next_div_cnt;
  logic [CAL_WIN_LOG2-1:0] cal_cnt;
  logic [CAL_WIN_LOG2-1:0] next_cal_cnt;

  // Decode and strobes
  logic             req;
  logic             done;
  logic             acc_ok;
  logic             wr_ok;
  logic             wr_hit;
  logic [IDX_W:0]   dec;
  logic             dec_valid;
  logic [IDX_W-1:0] dec_idx;
  logic [15:0]      wd16;
  logic             evt_clr;
  logic             irq_clr;
  logic             level_hit;
  logic             active;
  logic             tamper_evt;
  logic             keep_tick;
  logic             sel_pulse;
  logic [31:0]      rd_word;

  assign req       = bus_req.read | bus_req.write;
  assign done      = req & ~bus_rsp.waitrequest;
  // Without the interface clocks nothing reaches the domain
  assign acc_ok    = power_iface_clock_enable & backup_iface_clock_enable;
  assign wr_ok     = acc_ok & domain_write_unlock;
  assign wr_hit    = done & bus_req.write & wr_ok;
  assign dec       = decode(bus_req.address);
  assign dec_valid = dec[IDX_W];
  assign dec_idx   = dec[IDX_W-1:0];
  assign wd16      = bus_req.writedata[15:0];
  assign evt_clr   = wr_hit & bus_req.address == STS_OFS & bus_req.byteenable[0]
                     & bus_req.writedata[STS_EVT_CLR_BIT];
  assign irq_clr   = wr_hit & bus_req.address == STS_OFS & bus_req.byteenable[0]
                     & bus_req.writedata[STS_IRQ_CLR_BIT];

  // Level compare, then edge of (enable AND level)
  assign level_hit  = ctrl.tamper_active_level ? ~pin_sync : pin_sync;
  assign active     = ctrl.tamper_pin_enable & level_hit;
  // Enabling onto an active level yields one event at once
  assign tamper_evt = active & ~det_prev;

  // Skip cal_value ticks in every window
  assign keep_tick  = cal_cnt >= CAL_WIN_LOG2'(cal.cal_value);
  assign sel_pulse  = cal.pulse_second ? second_pulse : alarm_pulse;
  assign tamper_irq = irq_flag;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (acc_ok)
    begin
      if (dec_valid)
        rd_word = {16'h0000, mem[dec_idx]};
      else if (bus_req.address == CAL_OFS)
        rd_word = {20'h00000, cal};
      else if (bus_req.address == CTRL_OFS)
        rd_word = {30'h00000000, ctrl};
      else if (bus_req.address == STS_OFS)
      begin
        rd_word[STS_IRQ_BIT]    = irq_flag;
        rd_word[STS_EVT_BIT]    = evt_flag;
        rd_word[STS_IRQ_EN_BIT] = irq_en;
      end
    end
  end

  // Bus answer: waitrequest drops one cycle after the request
  always_comb
  begin
    next_rsp.waitrequest = ~(req & bus_rsp.waitrequest);
    next_rsp.readdata    = (bus_req.read & bus_rsp.waitrequest) ? rd_word : 32'h0000_0000;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_rsp.waitrequest <= 1'b1;
      bus_rsp.readdata    <= 32'h0000_0000;
    end
    else
      bus_rsp <= next_rsp;
  end

  // Register file; a tamper event beats a same-cycle write
  always_comb
  begin
    next_mem      = mem;
    next_cal      = cal;
    next_ctrl     = ctrl;
    next_irq_en   = irq_en;
    if (wr_hit)
    begin
      if (dec_valid)
        next_mem[dec_idx] = merge16(mem[dec_idx], wd16, bus_req.byteenable[1:0]);
      else if (bus_req.address == CAL_OFS)
        next_cal = cal_cfg_t'(12'(merge16({4'h0, cal}, wd16, bus_req.byteenable[1:0])));
      else if (bus_req.address == CTRL_OFS && bus_req.byteenable[0])
      begin
        next_ctrl.tamper_active_level = bus_req.writedata[CTRL_LVL_BIT];
        // Pulse output owns the pin, so tamper cannot be switched on
        next_ctrl.tamper_pin_enable   = bus_req.writedata[CTRL_EN_BIT] & ~cal.pulse_out_en;
      end
      else if (bus_req.address == STS_OFS && bus_req.byteenable[0])
        next_irq_en = bus_req.writedata[STS_IRQ_EN_BIT];
    end
    // Set wins over a same-cycle clear
    next_evt_flag = (evt_flag & ~evt_clr) | tamper_evt;
    next_irq_flag = (irq_flag & ~irq_clr) | (tamper_evt & irq_en);
    if (tamper_evt)
    begin
      for (int i = 0; i < NUM_WORDS; i++)
        next_mem[i] = '0;
    end
  end

  // Only the backup domain reset reaches these; no other reset exists here
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_WORDS; i++)
        mem[i] <= '0;
      cal      <= cal_cfg_t'(CAL_RESET);
      ctrl     <= tamper_ctrl_t'(CTRL_RESET);
      irq_en   <= 1'b0;
      evt_flag <= 1'b0;
      irq_flag <= 1'b0;
    end
    else
    begin
      mem      <= next_mem;
      cal      <= next_cal;
      ctrl     <= next_ctrl;
      irq_en   <= next_irq_en;
      evt_flag <= next_evt_flag;
      irq_flag <= next_irq_flag;
    end
  end

  // Pin side: detector, divider, calibration window, output mux
  always_comb
  begin
    next_det_prev = active;
    next_toggle_q = toggle_q ^ sel_pulse;
    next_cal_cnt  = cal_cnt + CAL_WIN_LOG2'(1);
    next_rtc_tick = keep_tick;
    next_div_cnt  = div_cnt + {{(DIV_LOG2-1){1'b0}},
                               (cal.cal_after ? keep_tick : 1'b1)};
    next_pin_out  = 1'b0;
    next_pin_oe   = 1'b0;
    if (ctrl.tamper_pin_enable)
      next_pin_oe = 1'b0;
    else if (cal.cal_clock_out_enable)
    begin
      next_pin_oe  = 1'b1;
      next_pin_out = div_cnt[DIV_LOG2-1];
    end
    else if (cal.pulse_out_en)
    begin
      next_pin_oe  = 1'b1;
      next_pin_out = cal.toggle_form ? toggle_q : sel_pulse;
    end
  end

  // Detection runs on this clock alone, which the backup supply keeps alive
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_meta       <= 1'b0;
      pin_sync       <= 1'b0;
      det_prev       <= 1'b0;
      toggle_q       <= 1'b0;
      div_cnt        <= '0;
      cal_cnt        <= '0;
      rtc_tick       <= 1'b0;
      tamper_pin_out <= 1'b0;
      tamper_pin_oe  <= 1'b0;
    end
    else
    begin
      pin_meta       <= tamper_pin_in;
      pin_sync       <= pin_meta;
      det_prev       <= next_det_prev;
      toggle_q       <= next_toggle_q;
      div_cnt        <= next_div_cnt;
      cal_cnt        <= next_cal_cnt;
      rtc_tick       <= next_rtc_tick;
      tamper_pin_out <= next_pin_out;
      tamper_pin_oe  <= next_pin_oe;
    end
  end

  // Checks
  logic [15:0] hit_word;
  assign hit_word = mem[dec_idx];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  AST_EVT_CLEARS: assert property (tamper_evt |=> mem[0] == '0 && mem[NUM_WORDS-1] == '0)
    else $error("words not cleared after tamper");
  AST_NO_DETECT_OFF: assert property (!ctrl.tamper_pin_enable |-> !tamper_evt)
    else $error("tamper event while disabled");
  AST_LEVEL_POLARITY: assert property (tamper_evt |->
    (ctrl.tamper_active_level ? !pin_sync : pin_sync))
    else $error("tamper event on inactive level");
  AST_EXTRA_HIGH: assert property ($rose(ctrl.tamper_pin_enable) &&
    !ctrl.tamper_active_level && pin_sync |-> tamper_evt)
    else $error("no event enabling onto high pin");
  AST_EXTRA_LOW: assert property ($rose(ctrl.tamper_pin_enable) &&
    ctrl.tamper_active_level && !pin_sync |-> tamper_evt)
    else $error("no event enabling onto low pin");
  AST_SINGLE_EVT: assert property (active && $past(active) |-> !tamper_evt)
    else $error("tamper event repeated without edge");
  AST_IRQ_SET: assert property (tamper_evt && irq_en |=> tamper_irq)
    else $error("interrupt missing after tamper");
  AST_IRQ_CLEAR: assert property (irq_clr && !tamper_evt |=> !tamper_irq)
    else $error("interrupt flag not cleared");
  AST_IRQ_HOLD: assert property (tamper_irq && !irq_clr |=> tamper_irq)
    else $error("interrupt dropped while flag set");
  AST_PIN_FREE: assert property (ctrl.tamper_pin_enable &&
    $past(ctrl.tamper_pin_enable) |-> !tamper_pin_oe)
    else $error("pin driven while tamper enabled");
  AST_LOCKED_WRITE: assert property (done && bus_req.write && !domain_write_unlock &&
    dec_valid && !tamper_evt |=> mem[$past(dec_idx)] == $past(hit_word))
    else $error("word written while locked");
  AST_WORD_STORE: assert property (wr_hit && dec_valid && !tamper_evt &&
    bus_req.byteenable == 4'hF |=> mem[$past(dec_idx)] == $past(wd16))
    else $error("word write lost");
  AST_ANSWER: assert property (req && bus_rsp.waitrequest |=> !bus_rsp.waitrequest)
    else $error("bus answer late");

  COV_TAMPER_IRQ: cover property (tamper_evt && irq_en ##1 tamper_irq);
  COV_EXTRA_EVT: cover property ($rose(ctrl.tamper_pin_enable) && tamper_evt);
  COV_CAL_OUT: cover property (tamper_pin_oe && cal.cal_clock_out_enable ##1 $rose(tamper_pin_out));
  COV_WORD_WRITE: cover property (wr_hit && dec_valid && dec_idx == 6'h3F);
endmodule // backup_domain_tamper_store
`default_nettype wire

/* logic/bkup_pkg.sv */
// Constants and carrier types for the backup domain tamper store
`default_nettype none
package bkup_pkg;
  // Geometry
  localparam int NUM_WORDS = 64;
  localparam int WORD_W    = 16;
  localparam int ADDR_W    = 9;
  localparam int DATA_W    = 32;
  localparam int IDX_W     = 6;
  localparam logic [5:0] LOW_COUNT = 6'h0A;
  // Byte offsets
  localparam logic [8:0] LOW_FIRST  = 9'h004;
  localparam logic [8:0] LOW_LAST   = 9'h028;
  localparam logic [8:0] CAL_OFS    = 9'h02C;
  localparam logic [8:0] CTRL_OFS   = 9'h030;
  localparam logic [8:0] STS_OFS    = 9'h034;
  localparam logic [8:0] HIGH_FIRST = 9'h040;
  localparam logic [8:0] HIGH_LAST  = 9'h114;
  // Control and status bit positions
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_LVL_BIT    = 1;
  localparam int STS_EVT_CLR_BIT = 0;
  localparam int STS_IRQ_CLR_BIT = 1;
  localparam int STS_IRQ_EN_BIT  = 2;
  localparam int STS_EVT_BIT     = 8;
  localparam int STS_IRQ_BIT     = 9;
  // Reset values and timing
  localparam logic [11:0] CAL_RESET  = 12'h000;
  localparam logic [1:0]  CTRL_RESET = 2'h0;
  localparam int DIV_LOG2         = 6;
  localparam int CAL_WIN_LOG2_DEF = 20;

  // Calibration register, bits 11:0
  typedef struct packed {
    logic       toggle_form;
    logic       cal_after;
    logic       pulse_second;
    logic       pulse_out_en;
    logic       cal_clock_out_enable;
    logic [6:0] cal_value;
  } cal_cfg_t;

  // Control register, bits 1:0
  typedef struct packed {
    logic tamper_active_level;
    logic tamper_pin_enable;
  } tamper_ctrl_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [8:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } avmm_req_t;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
  } avmm_rsp_t;
endpackage
`default_nettype wire

/* test/tamper_switch_model.sv */
// External tamper switch sharing the tamper pin with the block
`timescale 1ns/1ps
`default_nettype none
module tamper_switch_model (
  // Switch position chosen by the scenario
  input  wire logic switch_level,
  // Block side of the pin
  input  wire logic pin_out,
  input  wire logic pin_oe,
  // Resolved pin level
  output logic      pin_level
);
  // Switch sits behind a series resistor, so the block wins while it drives
  assign pin_level = pin_oe ? pin_out : switch_level;
endmodule // tamper_switch_model
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the backup domain tamper store
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bkup_pkg::*;
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
  $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); end end

  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        power_iface_clock_enable = 1'b0;
  logic        backup_iface_clock_enable = 1'b0;
  logic        domain_write_unlock = 1'b0;
  logic        switch_level = 1'b0;
  logic        alarm_pulse = 1'b0;
  logic        second_pulse = 1'b0;
  logic        prev_out;
  avmm_req_t   bus_req = '0;
  avmm_rsp_t   bus_rsp;
  logic        pin_out, pin_oe, pin_level, rtc_tick, tamper_irq;
  logic [15:0] mem [NUM_WORDS];
  logic [31:0] rd;
  logic [6:0]  cal;
  integer      seed = 32'h2424;
  int          err_total = 0;
  int          tests_run = 0;
  int          cyc;

  always #4 core_clk = ~core_clk;

  backup_domain_tamper_store #(.CAL_WIN_LOG2(8)) i_backup_domain_tamper_store (
    .core_clk, .rst, .power_iface_clock_enable, .backup_iface_clock_enable,
    .domain_write_unlock, .bus_req, .bus_rsp, .tamper_pin_in(pin_level),
    .tamper_pin_out(pin_out), .tamper_pin_oe(pin_oe), .alarm_pulse,
    .second_pulse, .rtc_tick, .tamper_irq);

  tamper_switch_model i_tamper_switch_model (
    .switch_level, .pin_out, .pin_oe, .pin_level);

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Request held until waitrequest is sampled low, released after that edge
  task automatic bus(input logic wr, input logic [8:0] addr, input logic [31:0] wdata);
    int n;
    n = 0;
    @(posedge core_clk);
    bus_req <= '{read: !wr, write: wr, address: addr, byteenable: 4'hF, writedata: wdata};
    while (1)
    begin
      @(posedge core_clk);
      n++;
      if (bus_rsp.waitrequest === 1'b0 || n >= 100) break;
    end
    rd = bus_rsp.readdata;
    bus_req.read <= 1'b0;
    bus_req.write <= 1'b0;
    if (n >= 100)
    begin
      err_total++;
      results();
    end
  endtask

  function automatic logic [8:0] word_addr(input int idx);
    return (idx < 10) ? LOW_FIRST + 9'(idx * 4) : HIGH_FIRST + 9'((idx - 10) * 4);
  endfunction

  task automatic fill();
    for (int i = 0; i < NUM_WORDS; i++)
    begin
      mem[i] = 16'($random(seed));
      bus(1'b1, word_addr(i), {16'h0000, mem[i]});
    end
  endtask

  task automatic check_all();
    for (int i = 0; i < NUM_WORDS; i++)
    begin
      bus(1'b0, word_addr(i), 32'h0);
      `CHK(rd, {16'h0000, mem[i]})
    end
  endtask

  task automatic wait_rise(output int n);
    logic prev;
    n = 0;
    prev = 1'b1;
    while (!(prev === 1'b0 && pin_out === 1'b1) && n < 300)
    begin
      prev = pin_out;
      @(posedge core_clk);
      n++;
    end
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    results();
  end

  initial
  begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    foreach (mem[i]) mem[i] = 16'h0000;
    bus(1'b1, LOW_FIRST, 32'h0000_1234);
    bus(1'b0, LOW_FIRST, 32'h0);
    `CHK(rd, 32'h0)
    power_iface_clock_enable <= 1'b1;
    backup_iface_clock_enable <= 1'b1;
    bus(1'b1, LOW_FIRST, 32'h0000_1234);
    bus(1'b0, LOW_FIRST, 32'h0);
    `CHK(rd, 32'h0)
    domain_write_unlock <= 1'b1;
    fill();
    check_all();
    bus(1'b0, 9'h038, 32'h0);
    `CHK(rd, 32'h0)
    switch_level <= 1'b1;
    repeat (8) @(posedge core_clk);
    check_all();
    `CHK(pin_oe, 1'b0)
    switch_level <= 1'b0;
    bus(1'b1, STS_OFS, 32'h4);
    bus(1'b1, CTRL_OFS, 32'h1);
    repeat (4) @(posedge core_clk);
    switch_level <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK(tamper_irq, 1'b1)
    bus(1'b0, STS_OFS, 32'h0);
    `CHK(rd, 32'h0000_0304)
    foreach (mem[i]) mem[i] = 16'h0000;
    check_all();
    `CHK(tamper_irq, 1'b1)
    bus(1'b1, STS_OFS, 32'h7);
    bus(1'b0, STS_OFS, 32'h0);
    `CHK(rd, 32'h0000_0004)
    `CHK(tamper_irq, 1'b0)
    // Level changed only while disabled, as a spurious event follows otherwise
    for (int lvl = 0; lvl < 2; lvl++)
    begin
      bus(1'b1, CTRL_OFS, 32'h0);
      switch_level <= (lvl == 0);
      bus(1'b1, CTRL_OFS, 32'(lvl * 2));
      fill();
      check_all();
      bus(1'b1, CTRL_OFS, 32'(lvl * 2 + 1));
      repeat (4) @(posedge core_clk);
      foreach (mem[i]) mem[i] = 16'h0000;
      if (lvl == 0) check_all();
      else check_all();
      `CHK(tamper_irq, 1'b1)
      bus(1'b1, STS_OFS, 32'h7);
    end
    bus(1'b1, CTRL_OFS, 32'h2);
    bus(1'b1, CTRL_OFS, 32'h0);
    // Pulse output: second pulse selected, alarm ignored
    bus(1'b1, CAL_OFS, 32'h0000_0300);
    second_pulse <= 1'b1;
    @(posedge core_clk);
    second_pulse <= 1'b0;
    alarm_pulse <= 1'b1;
    @(posedge core_clk);
    alarm_pulse <= 1'b0;
    `CHK(pin_out, 1'b1)
    @(posedge core_clk);
    `CHK(pin_out, 1'b0)
    // Pulse output owns the pin, so tamper enable is refused
    bus(1'b1, CTRL_OFS, 32'h1);
    bus(1'b0, CTRL_OFS, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(pin_oe, 1'b1)
    // Toggle form on the alarm pulse
    bus(1'b1, CAL_OFS, 32'h0000_0900);
    @(posedge core_clk);
    alarm_pulse <= 1'b1;
    @(posedge core_clk);
    prev_out = pin_out;
    alarm_pulse <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK(pin_out, ~prev_out)
    cal = 7'($random(seed));
    bus(1'b1, CAL_OFS, {24'h0, 1'b1, cal});
    repeat (3) @(posedge core_clk);
    `CHK(pin_oe, 1'b1)
    wait_rise(cyc);
    wait_rise(cyc);
    `CHK(cyc, 64)
    cyc = 0;
    repeat (256)
    begin
      @(posedge core_clk);
      if (rtc_tick === 1'b0) cyc++;
    end
    `CHK(cyc, int'(cal))
    bus(1'b1, CTRL_OFS, 32'h1);
    repeat (3) @(posedge core_clk);
    `CHK(pin_oe, 1'b0)
    // Words survive until the backup domain reset
    bus(1'b1, HIGH_LAST, 32'h0000_A5A5);
    bus(1'b0, HIGH_LAST, 32'h0);
    `CHK(rd, 32'h0000_A5A5)
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    bus(1'b0, HIGH_LAST, 32'h0);
    `CHK(rd, 32'h0)
    results();
  end
endmodule // tb_top
`default_nettype wire
